/* design/touch_queue_pkg.sv */
// constants shared by the touch sample queue readout
package touch_queue_pkg;
   localparam int QUEUE_DEPTH = 128;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_PANEL = 8'h40;
   localparam logic [7:0] IDX_THRESHOLD = 8'h4a;
   localparam logic [7:0] IDX_STATUS = 8'h4b;
   localparam logic [7:0] IDX_COUNT = 8'h4c;
   localparam logic [7:0] IDX_XVAL = 8'h4e;
   localparam logic [7:0] IDX_YVAL = 8'h4f;
   localparam logic [7:0] IDX_ZVAL = 8'h51;
   localparam logic [7:0] IDX_PORT_INC = 8'h57;
   localparam logic [7:0] IDX_PORT_FIX = 8'h07;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h0b;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h0a;
   // queue_status_control fields
   localparam int STS_OVERRUN_BIT = 7;
   localparam int STS_FULL_BIT = 6;
   localparam int STS_EMPTY_BIT = 5;
   localparam int STS_LEVEL_BIT = 4;
   localparam int STS_CLEAR_BIT = 0;
   localparam logic [7:0] STATUS_RESET = 8'h20;
   // panel_control_reg fields
   localparam int PANEL_ENABLE_BIT = 0;
   localparam int PANEL_MODE_LSB = 1;
   localparam logic [7:0] PANEL_RESET = 8'h00;
   localparam logic [7:0] THRESHOLD_RESET = 8'h00;
   // interrupt status / mask fields
   localparam int IRQ_LEVEL_BIT = 0;
   localparam int IRQ_OVERRUN_BIT = 1;
   localparam int IRQ_FULL_BIT = 2;
   localparam logic [2:0] IRQ_RESET = 3'h0;
   // acquisition_select encodings
   localparam logic [2:0] MODE_XYZ = 3'h0;
   localparam logic [2:0] MODE_XY = 3'h1;
   localparam logic [2:0] MODE_X = 3'h2;
   localparam logic [2:0] MODE_Y = 3'h3;
   localparam logic [2:0] MODE_Z = 3'h4;
endpackage : touch_queue_pkg

/* design/touch_sample_fifo_readout.sv */
// touch sample queue with APB register readout and packed byte port
// Function
// R1: overrun flag set once a sample is lost to a full queue.
// R2: status register: overrun, full, empty, level flags, clear bit; resets 0x20.
// R3: read-only count register shows samples held; resets to zero.
// R4: byte port readable at an advancing and a fixed address.
// R5: host drains the whole queue through the fixed address.
// R6: byte layout follows the acquisition_select field of panel control.
// R7: mode 000: X hi, X lo with Y hi, Y lo, Z.
// R8: mode 001: X hi, X lo with Y hi, Y lo.
// R9: mode 010 X two bytes, 011 Y two bytes, 100 Z one byte.
// R10: both port addresses give the same data; address alone selects.
// R11: byte port read-only, each read gives the next byte, resets zero.
// R12: queue held cleared after reset until the panel enable is set.
// R13: level interrupt keeps setting while count exceeds threshold.
// R14: sample popped and count decremented after its last byte is read.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module touch_sample_fifo_readout #(
   parameter int DEPTH = touch_queue_pkg::QUEUE_DEPTH
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // samples from acquisition
   input wire logic sampleValid,
   input wire logic [11:0] sampleX,
   input wire logic [11:0] sampleY,
   input wire logic [7:0] sampleZ,
   // panel control to acquisition
   output logic panelEnable,
   output logic [2:0] acquisitionSelect,
   // interrupt
   output logic irq
);
   import touch_queue_pkg::*;

   localparam int AW = $clog2(DEPTH);

   // count register is eight bits, so the queue cannot grow past 128
   if (DEPTH < 2 || DEPTH > 128 || (1 << AW) != DEPTH) begin : g_depth_chk
      $error("DEPTH must be a power of two from 2 to 128");
   end

   logic [11:0] memX [DEPTH];
   logic [11:0] memY [DEPTH];
   logic [7:0] memZ [DEPTH];
   logic [AW-1:0] wrPtr_reg;
   logic [AW-1:0] rdPtr_reg;
   logic [7:0] count_reg;
   logic [7:0] count_next;
   logic [1:0] byteIdx_reg;
   logic overrun_reg;
   logic clear_reg;
   logic [7:0] panel_reg;
   logic [7:0] threshold_reg;
   logic [2:0] irqStatus_reg;
   logic [2:0] irqStatus_next;
   logic [2:0] irqMask_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic irq_reg;
   logic enablePrev_reg;
   logic portLive_reg;

   // bus decode
   wire [7:0] idx = paddr[9:2];
   wire setup = psel & ~penable;
   wire done = psel & penable & pready_reg;
   wire isPort = (idx == IDX_PORT_INC) | (idx == IDX_PORT_FIX); // [R4] [R10]
   wire mapped = isPort | (idx == IDX_STATUS) | (idx == IDX_COUNT) |
      (idx == IDX_XVAL) | (idx == IDX_YVAL) | (idx == IDX_ZVAL) |
      (idx == IDX_PANEL) | (idx == IDX_THRESHOLD) |
      (idx == IDX_IRQ_STATUS) | (idx == IDX_IRQ_MASK);
   wire wrDone = done & pwrite;
   // a byte that lands after an empty setup must not be consumed unseen
   wire portRead = done & ~pwrite & isPort & portLive_reg;

   // queue state
   wire enableBit = panel_reg[PANEL_ENABLE_BIT];
   wire [2:0] mode = panel_reg[PANEL_MODE_LSB +: 3];
   wire clearActive = clear_reg | ~enableBit; // [R12]
   wire empty = (count_reg == 8'h00);
   wire full = (count_reg == 8'(DEPTH));
   wire [11:0] headX = empty ? 12'h000 : memX[rdPtr_reg];
   wire [11:0] headY = empty ? 12'h000 : memY[rdPtr_reg];
   wire [7:0] headZ = empty ? 8'h00 : memZ[rdPtr_reg];

   // bytes per packed sample and the byte now due
   wire [1:0] lastIdx = (mode == MODE_XY) ? 2'h2 :
      ((mode == MODE_X) | (mode == MODE_Y)) ? 2'h1 :
      (mode == MODE_Z) ? 2'h0 : 2'h3; // [R6]
   wire lastByte = (byteIdx_reg >= lastIdx);
   logic [7:0] portByte;
   always_comb begin
      portByte = 8'h00;
      if (!empty) begin
         case (mode) // [R6]
            MODE_XY: begin
               case (byteIdx_reg) // [R8]
                  2'h0: portByte = headX[11:4];
                  2'h1: portByte = {headX[3:0], headY[11:8]};
                  default: portByte = headY[7:0];
               endcase
            end
            MODE_X: begin
               portByte = (byteIdx_reg == 2'h0) ? headX[11:4] :
                  {4'h0, headX[3:0]}; // [R9]
            end
            MODE_Y: begin
               portByte = (byteIdx_reg == 2'h0) ? headY[11:4] :
                  {4'h0, headY[3:0]}; // [R9]
            end
            MODE_Z: begin
               portByte = headZ; // [R9]
            end
            default: begin
               case (byteIdx_reg) // [R7]
                  2'h0: portByte = headX[11:4];
                  2'h1: portByte = {headX[3:0], headY[11:8]};
                  2'h2: portByte = headY[7:0];
                  default: portByte = headZ;
               endcase
            end
         endcase
      end
   end

   // push, pop, overrun
   wire pop = portRead & ~empty & lastByte & ~clearActive; // [R14]
   wire push = sampleValid & ~clearActive & (~full | pop);
   wire lost = sampleValid & ~clearActive & full & ~pop; // [R1]
   wire levelHit = (threshold_reg != 8'h00) &&
      (count_reg > threshold_reg); // [R13]
   wire levelFlag = (threshold_reg != 8'h00) &&
      (count_reg >= threshold_reg);

   always_comb begin
      count_next = count_reg;
      if (clearActive) begin
         count_next = 8'h00;
      end else if (push & ~pop) begin
         count_next = count_reg + 8'h01; // [R3]
      end else if (pop & ~push) begin
         count_next = count_reg - 8'h01; // [R14]
      end
   end

   wire [7:0] statusValue = {overrun_reg, full, empty, levelFlag,
      3'h0, clear_reg}; // [R2]

   // interrupt: set wins over write-one-to-clear
   wire [2:0] irqSet;
   assign irqSet[IRQ_LEVEL_BIT] = levelHit; // [R13]
   assign irqSet[IRQ_OVERRUN_BIT] = lost;
   assign irqSet[IRQ_FULL_BIT] = push & ~pop & (count_reg == 8'(DEPTH - 1));
   wire [2:0] irqClr = (wrDone && idx == IDX_IRQ_STATUS) ?
      pwdata[2:0] : 3'h0;
   assign irqStatus_next = (irqStatus_reg & ~irqClr) | irqSet;

   // read mux, sampled in the setup phase
   logic [31:0] readValue;
   always_comb begin
      readValue = 32'h0000_0000;
      case (idx)
         IDX_STATUS: readValue = {24'h00_0000, statusValue};
         IDX_COUNT: readValue = {24'h00_0000, count_reg}; // [R3]
         IDX_XVAL: readValue = {20'h0_0000, headX};
         IDX_YVAL: readValue = {20'h0_0000, headY};
         IDX_ZVAL: readValue = {24'h00_0000, headZ};
         IDX_PORT_INC: readValue = {24'h00_0000, portByte}; // [R11]
         IDX_PORT_FIX: readValue = {24'h00_0000, portByte}; // [R11]
         IDX_PANEL: readValue = {24'h00_0000, panel_reg};
         IDX_THRESHOLD: readValue = {24'h00_0000, threshold_reg};
         IDX_IRQ_STATUS: readValue = {29'h0, irqStatus_reg};
         IDX_IRQ_MASK: readValue = {29'h0, irqMask_reg};
         default: readValue = 32'h0000_0000;
      endcase
   end

   // apb answer: ready in the first access cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         portLive_reg <= 1'b0;
      end else begin
         pready_reg <= setup;
         pslverr_reg <= setup & ~mapped;
         if (setup) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : readValue;
            portLive_reg <= ~empty;
         end
      end
   end

   // software registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         panel_reg <= PANEL_RESET;
         threshold_reg <= THRESHOLD_RESET;
         irqMask_reg <= IRQ_RESET;
      end else if (wrDone) begin
         if (idx == IDX_PANEL) begin
            panel_reg <= pwdata[7:0];
         end
         if (idx == IDX_THRESHOLD) begin
            threshold_reg <= pwdata[7:0];
         end
         if (idx == IDX_IRQ_MASK) begin
            irqMask_reg <= pwdata[2:0];
         end
      end
   end

   // clear bit: set by software, dropped when enable rises
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         clear_reg <= 1'b0;
         enablePrev_reg <= 1'b0;
      end else begin
         enablePrev_reg <= enableBit;
         if (wrDone && idx == IDX_STATUS) begin
            clear_reg <= pwdata[STS_CLEAR_BIT];
         end else if (enableBit & ~enablePrev_reg) begin
            clear_reg <= 1'b0; // [R12]
         end
      end
   end

   // queue pointers, count, byte index, overrun
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= 8'h00;
         byteIdx_reg <= 2'h0;
         overrun_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         if (clearActive) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            byteIdx_reg <= 2'h0;
            overrun_reg <= 1'b0;
         end else begin
            if (push) begin
               wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (pop) begin
               rdPtr_reg <= rdPtr_reg + 1'b1; // [R14]
            end
            if (portRead & ~empty) begin
               byteIdx_reg <= lastByte ? 2'h0 : byteIdx_reg + 2'h1; // [R11]
            end
            if (lost) begin
               overrun_reg <= 1'b1; // [R1]
            end
         end
      end
   end

   // sample storage, no reset needed
   always_ff @(posedge clk_sys) begin
      if (push) begin
         memX[wrPtr_reg] <= sampleX;
         memY[wrPtr_reg] <= sampleY;
         memZ[wrPtr_reg] <= sampleZ;
      end
   end

   // interrupt status and output
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irqStatus_reg <= IRQ_RESET;
         irq_reg <= 1'b0;
      end else begin
         irqStatus_reg <= irqStatus_next;
         irq_reg <= |(irqStatus_next & irqMask_reg);
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign panelEnable = panel_reg[PANEL_ENABLE_BIT];
   assign acquisitionSelect = panel_reg[PANEL_MODE_LSB +: 3];
   assign irq = irq_reg;

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   AST_OVERRUN_SET: assert property (lost |=> overrun_reg) // [R1]
      else $error("overrun not flagged after lost sample");
   AST_STATUS_EMPTY: assert property (
      setup && !pwrite && idx == IDX_STATUS |=>
      prdata_reg[STS_EMPTY_BIT] == ($past(count_reg) == 8'h00)) // [R2]
      else $error("empty flag disagrees with count");
   AST_COUNT_UP: assert property (
      push && !pop && !clearActive |=>
      count_reg == $past(count_reg) + 8'h01) // [R3]
      else $error("count did not rise on push");
   AST_COUNT_DOWN: assert property (
      pop && !push |=> count_reg == $past(count_reg) - 8'h01) // [R14]
      else $error("count did not fall on pop");
   AST_EMPTY_PORT_ZERO: assert property (
      setup && !pwrite && isPort && empty |=> prdata_reg == 32'h0) // [R11]
      else $error("empty port read not zero");
   AST_XYZ_LAST_Z: assert property (
      setup && !pwrite && isPort && !empty && mode == MODE_XYZ &&
      byteIdx_reg == 2'h3 |=> prdata_reg[7:0] == $past(headZ)) // [R7]
      else $error("fourth byte in mode 000 is not Z");
   AST_HELD_CLEAR: assert property (
      !enableBit |=> count_reg == 8'h00) // [R12]
      else $error("queue not held clear while disabled");
   AST_LEVEL_RESET: assert property (
      levelHit |=> irqStatus_reg[IRQ_LEVEL_BIT]) // [R13]
      else $error("level interrupt not reasserted");
   AST_PORT_ADVANCE: assert property (
      portRead && !empty && !lastByte && !clearActive |=>
      byteIdx_reg == $past(byteIdx_reg) + 2'h1) // [R11]
      else $error("byte index did not advance");
   AST_READY_ONE: assert property (setup |=> pready_reg ##1 !pready_reg)
      else $error("pready not a single access cycle");

   COV_OVERRUN: cover property (lost);
   COV_POP: cover property (pop ##[1:20] pop);
   COV_IRQ: cover property (irq_reg);
   COV_CLEAR: cover property (wrDone && idx == IDX_STATUS && pwdata[0]);
endmodule : touch_sample_fifo_readout
`default_nettype wire

/* test/sample_source.sv */
// acquisition-side model that hands samples to the queue
`timescale 1ns/1ns
`default_nettype none
module sample_source (
   // clock
   input wire logic clk_sys,
   // sample output
   output logic sampleValid,
   output logic [11:0] sampleX,
   output logic [11:0] sampleY,
   output logic [7:0] sampleZ
);
   initial begin
      sampleValid = 1'b0;
      sampleX = 12'h000;
      sampleY = 12'h000;
      sampleZ = 8'h00;
   end
   // one-cycle pulse; fields scrambled afterwards so a late capture shows
   task automatic push(input logic [11:0] x, input logic [11:0] y,
         input logic [7:0] z);
      @(posedge clk_sys);
      sampleValid <= 1'b1;
      sampleX <= x;
      sampleY <= y;
      sampleZ <= z;
      @(posedge clk_sys);
      sampleValid <= 1'b0;
      sampleX <= ~x;
      sampleY <= ~y;
      sampleZ <= ~z;
   endtask : push
endmodule : sample_source
`default_nettype wire

/* test/touch_sample_fifo_readout_tb.sv */
// self-checking bench for the touch sample queue readout
`timescale 1ns/1ns
`default_nettype none
module touch_sample_fifo_readout_tb;
   import touch_queue_pkg::*;
   localparam int DEPTH = 4;
   logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, lastErr;
   logic [9:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic sampleValid, panelEnable, irq;
   logic [11:0] sampleX, sampleY;
   logic [7:0] sampleZ;
   logic [2:0] acquisitionSelect;
   int error_cnt, checks_done;

   touch_sample_fifo_readout #(.DEPTH(DEPTH)) touch_sample_fifo_readout_i (
      .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sampleValid(sampleValid),
      .sampleX(sampleX), .sampleY(sampleY), .sampleZ(sampleZ),
      .panelEnable(panelEnable), .acquisitionSelect(acquisitionSelect),
      .irq(irq));
   sample_source sample_source_i (.clk_sys(clk_sys),
      .sampleValid(sampleValid), .sampleX(sampleX), .sampleY(sampleY),
      .sampleZ(sampleZ));

   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // master never assumes a latency; bounded wait for pready
   task automatic apb(input logic wr, input logic [7:0] idx,
         input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'h0};
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         error_cnt++;
         $display("unexpected pready expected 1 seen %b", pready);
         report_and_stop();
      end else begin
         rdata = prdata;
         lastErr = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   task automatic rd(input logic [7:0] idx, input logic [31:0] exp,
         input string what);
      apb(1'b0, idx, 32'h0);
      chk(what, exp, rdata);
   endtask : rd

   function automatic logic [7:0] pbyte(input logic [2:0] m, input int b,
         input logic [11:0] x, input logic [11:0] y, input logic [7:0] z);
      logic [7:0] g [4];
      g[0] = x[11:4];
      g[1] = {x[3:0], y[11:8]};
      g[2] = y[7:0];
      g[3] = z;
      case (m)
         MODE_X: return (b == 0) ? x[11:4] : {4'h0, x[3:0]};
         MODE_Y: return (b == 0) ? y[11:4] : {4'h0, y[3:0]};
         MODE_Z: return z;
         default: return g[b];
      endcase
   endfunction : pbyte

   task automatic t_start;
      rd(IDX_STATUS, 32'h20, "status at reset");
      rd(IDX_COUNT, 32'h0, "count at reset");
      rd(IDX_PORT_INC, 32'h0, "port at reset");
      sample_source_i.push(12'h111, 12'h222, 8'h33);
      repeat (2) @(posedge clk_sys);
      rd(IDX_COUNT, 32'h0, "count while held clear");
      apb(1'b1, IDX_PANEL, 32'h1);
      rd(IDX_STATUS, 32'h20, "status after enable");
      chk("panel enable", 32'h1, {31'h0, panelEnable});
   endtask : t_start

   task automatic t_modes;
      logic [2:0] m;
      logic [11:0] x, y;
      logic [7:0] z, e;
      int nb;
      for (int k = 0; k < 6; k++) begin
         m = 3'(k);
         x = 12'habc ^ 12'(k);
         y = 12'h123 + 12'(k);
         z = 8'h5a + 8'(k);
         nb = (k == 1) ? 3 : (k == 4) ? 1 : (k == 2 || k == 3) ? 2 : 4;
         apb(1'b1, IDX_PANEL, {28'h0, m, 1'b1});
         // register updates in the write edge's time step; look one later
         @(posedge clk_sys);
         chk("select", {29'h0, m}, {29'h0, acquisitionSelect});
         sample_source_i.push(x, y, z);
         repeat (2) @(posedge clk_sys);
         rd(IDX_COUNT, 32'h1, "count after push");
         for (int b = 0; b < nb; b++) begin
            e = pbyte(m, b, x, y, z);
            // alternate addresses; both must give the next byte
            rd((b % 2) ? IDX_PORT_FIX : IDX_PORT_INC, {24'h0, e}, "byte");
            if (b < nb - 1) rd(IDX_COUNT, 32'h1, "count mid group");
         end
         rd(IDX_COUNT, 32'h0, "count after group");
      end
      rd(IDX_PORT_INC, 32'h0, "port when empty");
   endtask : t_modes

   task automatic t_overrun;
      apb(1'b1, IDX_PANEL, 32'h1);
      apb(1'b1, IDX_IRQ_MASK, 32'h2);
      for (int k = 1; k <= DEPTH + 1; k++) begin
         sample_source_i.push(12'(k), 12'(k), 8'(k));
      end
      repeat (2) @(posedge clk_sys);
      rd(IDX_STATUS, 32'hc0, "status after loss");
      rd(IDX_COUNT, 32'(DEPTH), "count when full");
      rd(IDX_XVAL, 32'h1, "head x");
      chk("irq on overrun", 32'h1, {31'h0, irq});
      apb(1'b1, IDX_IRQ_STATUS, 32'h6);
      repeat (2) @(posedge clk_sys);
      chk("irq after clear", 32'h0, {31'h0, irq});
      apb(1'b1, IDX_STATUS, 32'h1);
      repeat (2) @(posedge clk_sys);
      rd(IDX_STATUS, 32'h21, "status while cleared");
      rd(IDX_COUNT, 32'h0, "count while cleared");
      apb(1'b1, IDX_PANEL, 32'h0);
      apb(1'b1, IDX_PANEL, 32'h1);
      rd(IDX_STATUS, 32'h20, "status after re-enable");
   endtask : t_overrun

   task automatic t_level;
      logic [7:0] e;
      apb(1'b1, IDX_THRESHOLD, 32'h1);
      apb(1'b1, IDX_IRQ_MASK, 32'h1);
      sample_source_i.push(12'h0f0, 12'h00f, 8'h77);
      sample_source_i.push(12'h0f1, 12'h00e, 8'h78);
      repeat (2) @(posedge clk_sys);
      rd(IDX_STATUS, 32'h10, "status level");
      apb(1'b1, IDX_IRQ_STATUS, 32'h1);
      repeat (2) @(posedge clk_sys);
      rd(IDX_IRQ_STATUS, 32'h1, "level flag re-set");
      chk("irq above level", 32'h1, {31'h0, irq});
      // drain both packed groups through the fixed address
      for (int b = 0; b < 8; b++) begin
         e = pbyte(MODE_XYZ, b % 4, (b < 4) ? 12'h0f0 : 12'h0f1,
            (b < 4) ? 12'h00f : 12'h00e, (b < 4) ? 8'h77 : 8'h78);
         rd(IDX_PORT_FIX, {24'h0, e}, "drained byte");
      end
      rd(IDX_COUNT, 32'h0, "count after drain");
      apb(1'b1, IDX_IRQ_STATUS, 32'h1);
      repeat (2) @(posedge clk_sys);
      chk("irq after drain", 32'h0, {31'h0, irq});
   endtask : t_level

   task automatic t_bus;
      rd(8'hff, 32'h0, "unmapped data");
      chk("unmapped error", 32'h1, {31'h0, lastErr});
      apb(1'b1, IDX_COUNT, 32'hff);
      rd(IDX_COUNT, 32'h0, "read-only count");
      chk("no error on read", 32'h0, {31'h0, lastErr});
   endtask : t_bus

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 10'h000;
      pwdata = 32'h0;
      error_cnt = 0;
      checks_done = 0;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      t_start();
      t_modes();
      t_overrun();
      t_level();
      t_bus();
      report_and_stop();
   end
endmodule : touch_sample_fifo_readout_tb
`default_nettype wire
